// File: sim/mce_error_log_monitor.sv
// Checker for the memory controller error logging block.
// Sees only the top ports; bound to the design below.
`timescale 1ns/1ps
module mce_error_log_monitor (
    input wire logic                   ref_clk,
    input wire logic                   rst_n,
    input wire logic                   evt_valid,
    input wire mce_pkg::mce_event_type evt,
    input wire logic [3:0]             reg_addr,
    input wire logic                   reg_read,
    input wire logic [31:0]            reg_rdata,
    input wire logic                   irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    chk_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside answer cycle");
    chk_unmapped_zero: assert property (reg_read && reg_addr > 4'h6 |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    chk_status_rsvd: assert property (reg_read && reg_addr == 4'h1 |=> !reg_rdata[5])
        else $error("status bit 37 not zero");
    chk_misc_rsvd: assert property (reg_read && reg_addr == 4'h3 |=> !reg_rdata[29:24])
        else $error("misc bits 61:56 not zero");
    chk_arch_code: assert property (evt_valid && evt.kind != mce_pkg::MCE_READ_CORR
        ##1 reg_read && reg_addr == 4'h0 |=> reg_rdata[15:0] ==
        {8'h00, 1'b1, $past(evt.req_type, 2), $past(evt.channel, 2)})
        else $error("architectural code mismatch");
    chk_model_code: assert property (evt_valid && evt.kind != mce_pkg::MCE_READ_CORR
        ##1 reg_read && reg_addr == 4'h0 |=> reg_rdata[31:16] == 16'h0001 << $past(evt.kind, 2))
        else $error("model code mismatch");
    chk_wdb_entry: assert property (evt_valid && evt.kind inside {4'h1, 4'h2, 4'h8}
        ##1 reg_read && reg_addr == 4'h2 |=> reg_rdata[13:9] == $past(evt.wdb_id, 2))
        else $error("buffer entry mismatch");
    chk_irq_reset: assert property ($rose(rst_n) |-> !irq)
        else $error("interrupt high after reset");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind mce_error_log mce_error_log_monitor mce_error_log_monitor_i (.ref_clk, .rst_n,
    .evt_valid, .evt, .reg_addr, .reg_read, .reg_rdata, .irq);

// File: sim/tb_mce_error_log.sv
// Testbench for the memory controller error logging block.
// Drives events and register accesses directly; no partner model.
`timescale 1ns/1ps
module tb_mce_error_log;
    logic                   ref_clk, rst_n, evt_valid, reg_write, reg_read, irq;
    logic [3:0]             reg_addr;
    logic [31:0]            reg_wdata, reg_rdata;
    mce_pkg::mce_event_type evt;
    int                     num_errors, check_count;
    localparam logic [15:0] M1 = 16'hA5C3;
    localparam logic [15:0] M2 = 16'h5A3C;
    mce_error_log mce_error_log_i (.ref_clk, .rst_n, .evt_valid, .evt, .reg_addr,
        .reg_wdata, .reg_write, .reg_read, .reg_rdata, .irq);
    always #2 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        evt_valid <= 1'b0;
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
        #1;
    endtask
    task rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        evt_valid <= 1'b0;
        reg_addr  <= a;
        reg_read  <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    // Event held one cycle; next access lowers it
    task ev(input int k, input logic [4:0] d, input logic [15:0] m, input logic [4:0] r);
        @(posedge ref_clk);
        evt_valid <= 1'b1;
        evt       <= {k[3:0], k[2:0], ~k[3:0], d, m, r, r};
    endtask
    task report_and_stop();
        $display("errors=%0d checks=%0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        num_errors++;
        report_and_stop();
    end
    initial begin
        {ref_clk, rst_n, evt_valid, reg_write, reg_read, reg_addr, reg_wdata} = '0;
        evt = '0;
        num_errors = 0;
        check_count = 0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 8; a++) rd(a[3:0], 32'h0);
        chk(irq, 32'h0);
        wr(mce_pkg::ADDR_CONTROL, 32'h2);
        for (int k = 0; k < 10; k++) begin
            ev(k, 5'h0, 16'h0, 5'h0);
            rd(mce_pkg::ADDR_STATUS_LO, {16'h1 << k, 8'h00, 1'b1, k[2:0], ~k[3:0]});
        end
        wr(mce_pkg::ADDR_MISC_LO, 32'h0);
        wr(mce_pkg::ADDR_MISC_HI, 32'h0);
        ev(7, 5'h0A, M1, 5'h11);
        rd(mce_pkg::ADDR_STATUS_HI, 32'h0000000A);
        rd(mce_pkg::ADDR_MISC_LO, {2'b00, M1, 14'h0});
        rd(mce_pkg::ADDR_MISC_HI, {2'b01, 11'h0, 5'h11, 14'h0});
        ev(7, 5'h03, M2, 5'h07);
        rd(mce_pkg::ADDR_MISC_LO, {M2[1:0], M1, 5'h03, 9'h0});
        rd(mce_pkg::ADDR_MISC_HI, {2'b11, 6'h0, 5'h07, 5'h11, M2[15:2]});
        wr(mce_pkg::ADDR_CONTROL, 32'h0);
        wr(mce_pkg::ADDR_STATUS_LO, 32'h0);
        ev(7, 5'h1F, M2, 5'h1F);
        rd(mce_pkg::ADDR_STATUS_LO, 32'h0);
        wr(mce_pkg::ADDR_IRQ_STAT, 32'h7);
        wr(mce_pkg::ADDR_IRQ_MASK, 32'h1);
        ev(3, 5'h1F, M2, 5'h1F);
        rd(mce_pkg::ADDR_STATUS_HI, 32'h0000000A);
        chk(irq, 32'h1);
        wr(mce_pkg::ADDR_IRQ_STAT, 32'h1);
        chk(irq, 32'h0);
        ev(2, 5'h0, 16'h0, 5'h15);
        rd(mce_pkg::ADDR_MISC_LO, {M2[1:0], M1, 5'h15, 9'h0});
        chk(irq, 32'h1);
        wr(mce_pkg::ADDR_IRQ_MASK, 32'h0);
        chk(irq, 32'h0);
        wr(mce_pkg::ADDR_STATUS_HI, 32'hFFFFFFFF);
        rd(mce_pkg::ADDR_STATUS_HI, 32'hFFFFFFDF);
        wr(mce_pkg::ADDR_MISC_HI, 32'hFFFFFFFF);
        rd(mce_pkg::ADDR_MISC_HI, 32'hC0FFFFFF);
        wr(4'hF, 32'hFFFFFFFF);
        rd(4'hF, 32'h0);
        report_and_stop();
    end
endmodule

// File: src/mce_error_log.sv
// Memory controller error logging: status and misc capture, control,
// interrupt status and mask. Events come from same-clock logic.
`timescale 1ns/1ps

module mce_error_log (
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    input  wire logic                 evt_valid,
    input  wire mce_pkg::mce_event_type evt,
    input  wire logic [3:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_write,
    input  wire logic                 reg_read,
    output logic      [31:0]          reg_rdata,
    output logic                      irq
);

    ////////////////////////////////////////////////////////////////////
    // State
    mce_pkg::mce_status_type status,    next_status;
    mce_pkg::mce_misc_type   misc,      next_misc;
    logic [31:0]             control,   next_control;
    logic [mce_pkg::IRQ_W-1:0] irq_stat, next_irq_stat;
    logic [mce_pkg::IRQ_W-1:0] irq_mask, next_irq_mask;
    logic [31:0]             rdata,     next_rdata;

    logic                    ext_log;
    logic                    accept;
    logic                    is_corr_read;
    logic                    is_wr_parity;
    logic [15:0]             model_code;
    logic [mce_pkg::IRQ_W-1:0] irq_set;

    assign ext_log = control[mce_pkg::CTRL_EXT_LOG_BIT];
    assign is_corr_read = (evt.kind == mce_pkg::MCE_READ_CORR);
    assign is_wr_parity = (evt.kind == mce_pkg::MCE_HA_WR_DATA) ||
                          (evt.kind == mce_pkg::MCE_BYTE_ENABLE) ||
                          (evt.kind == mce_pkg::MCE_WDB_PARITY);
    // Corrected reads are dropped unless extended logging is on
    assign accept = evt_valid && (!is_corr_read || ext_log);

    ////////////////////////////////////////////////////////////////////
    // Model-specific code
    always_comb begin
        case (evt.kind)
            mce_pkg::MCE_ADDR_PARITY:  model_code = mce_pkg::MS_ADDR_PARITY;
            mce_pkg::MCE_HA_WR_DATA:   model_code = mce_pkg::MS_HA_WR_DATA;
            mce_pkg::MCE_BYTE_ENABLE:  model_code = mce_pkg::MS_BYTE_ENABLE;
            mce_pkg::MCE_SCRUB_CORR:   model_code = mce_pkg::MS_SCRUB_CORR;
            mce_pkg::MCE_SCRUB_UNCORR: model_code = mce_pkg::MS_SCRUB_UNCORR;
            mce_pkg::MCE_SPARE_CORR:   model_code = mce_pkg::MS_SPARE_CORR;
            mce_pkg::MCE_SPARE_UNCORR: model_code = mce_pkg::MS_SPARE_UNCORR;
            mce_pkg::MCE_READ_CORR:    model_code = mce_pkg::MS_READ_CORR;
            mce_pkg::MCE_WDB_PARITY:   model_code = mce_pkg::MS_WDB_PARITY;
            mce_pkg::MCE_CA_PARITY:    model_code = mce_pkg::MS_CA_PARITY;
            default:                   model_code = 16'h0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Capture and register writes
    always_comb begin
        next_status   = status;
        next_misc     = misc;
        next_control  = control;
        next_irq_mask = irq_mask;
        irq_set       = '0;

        // Software writes first, a same-cycle event overrides
        if (reg_write) begin
            case (reg_addr)
                mce_pkg::ADDR_STATUS_LO: next_status[31:0] = reg_wdata;
                mce_pkg::ADDR_STATUS_HI: next_status[63:32] = reg_wdata;
                mce_pkg::ADDR_MISC_LO:   next_misc[31:0] = reg_wdata;
                mce_pkg::ADDR_MISC_HI:   next_misc[63:32] = reg_wdata;
                mce_pkg::ADDR_CONTROL:   next_control = reg_wdata;
                mce_pkg::ADDR_IRQ_MASK:  next_irq_mask = reg_wdata[mce_pkg::IRQ_W-1:0];
                default: begin
                end
            endcase
        end

        if (accept) begin
            next_status.arch_error_code = {mce_pkg::ARCH_UPPER, mce_pkg::ARCH_MARK,
                                           evt.req_type, evt.channel};
            next_status.model_code = model_code;
            irq_set[mce_pkg::IRQ_ERROR] = 1'b1;
            if (is_wr_parity) begin
                next_misc.info_13_9 = evt.wdb_id;
            end
            if (ext_log) begin
                if (is_corr_read && misc.valid_first) begin
                    // Second correctable read
                    next_misc.info_13_9   = evt.device_id;
                    next_misc.second_mask = evt.bit_mask;
                    next_misc.second_rank = evt.rank;
                    next_misc.valid_second = 1'b1;
                    irq_set[mce_pkg::IRQ_SECOND] = 1'b1;
                end else begin
                    next_status.first_device = evt.device_id;
                    next_misc.first_mask = evt.bit_mask;
                    next_misc.first_rank = evt.rank;
                    if (is_corr_read) begin
                        next_misc.valid_first = 1'b1;
                        irq_set[mce_pkg::IRQ_FIRST] = 1'b1;
                    end
                end
            end
        end

        next_status.reserved_37 = 1'b0;
        next_misc.reserved_hi   = '0;
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt status: write one to clear, set wins
    always_comb begin
        next_irq_stat = irq_stat;
        if (reg_write && reg_addr == mce_pkg::ADDR_IRQ_STAT) begin
            next_irq_stat = irq_stat & ~reg_wdata[mce_pkg::IRQ_W-1:0];
        end
        next_irq_stat = next_irq_stat | irq_set;
    end

    ////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (reg_read) begin
            case (reg_addr)
                mce_pkg::ADDR_STATUS_LO: next_rdata = status[31:0];
                mce_pkg::ADDR_STATUS_HI: next_rdata = status[63:32];
                mce_pkg::ADDR_MISC_LO:   next_rdata = misc[31:0];
                mce_pkg::ADDR_MISC_HI:   next_rdata = misc[63:32];
                mce_pkg::ADDR_CONTROL:   next_rdata = control;
                mce_pkg::ADDR_IRQ_STAT:  next_rdata = {29'h0, irq_stat};
                mce_pkg::ADDR_IRQ_MASK:  next_rdata = {29'h0, irq_mask};
                default:                 next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            status   <= '0;
            misc     <= '0;
            control  <= 32'h0000_0000;
            irq_stat <= '0;
            irq_mask <= '0;
            rdata    <= 32'h0000_0000;
        end else begin
            status   <= next_status;
            misc     <= next_misc;
            control  <= next_control;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            rdata    <= next_rdata;
        end
    end

    assign reg_rdata = rdata;
    assign irq       = |(irq_stat & irq_mask);

endmodule

// File: src/mce_pkg.sv
// Package for the memory controller error logging block.
// Assumes a single clock domain and a plain register port.
package mce_pkg;

    // Register map, 64-bit registers split into 32-bit words
    localparam logic [3:0] ADDR_STATUS_LO = 4'h0;
    localparam logic [3:0] ADDR_STATUS_HI = 4'h1;
    localparam logic [3:0] ADDR_MISC_LO   = 4'h2;
    localparam logic [3:0] ADDR_MISC_HI   = 4'h3;
    localparam logic [3:0] ADDR_CONTROL   = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STAT  = 4'h5;
    localparam logic [3:0] ADDR_IRQ_MASK  = 4'h6;

    localparam int CTRL_EXT_LOG_BIT = 1;

    // Model-specific codes
    localparam logic [15:0] MS_ADDR_PARITY   = 16'h0001;
    localparam logic [15:0] MS_HA_WR_DATA    = 16'h0002;
    localparam logic [15:0] MS_BYTE_ENABLE   = 16'h0004;
    localparam logic [15:0] MS_SCRUB_CORR    = 16'h0008;
    localparam logic [15:0] MS_SCRUB_UNCORR  = 16'h0010;
    localparam logic [15:0] MS_SPARE_CORR    = 16'h0020;
    localparam logic [15:0] MS_SPARE_UNCORR  = 16'h0040;
    localparam logic [15:0] MS_READ_CORR     = 16'h0080;
    localparam logic [15:0] MS_WDB_PARITY    = 16'h0100;
    localparam logic [15:0] MS_CA_PARITY     = 16'h0200;

    localparam logic [7:0]  ARCH_UPPER       = 8'h00;
    localparam logic        ARCH_MARK        = 1'b1;

    // Interrupt status bits
    localparam int IRQ_ERROR  = 0;
    localparam int IRQ_FIRST  = 1;
    localparam int IRQ_SECOND = 2;
    localparam int IRQ_W      = 3;

    typedef enum logic [3:0] {
        MCE_ADDR_PARITY,
        MCE_HA_WR_DATA,
        MCE_BYTE_ENABLE,
        MCE_SCRUB_CORR,
        MCE_SCRUB_UNCORR,
        MCE_SPARE_CORR,
        MCE_SPARE_UNCORR,
        MCE_READ_CORR,
        MCE_WDB_PARITY,
        MCE_CA_PARITY
    } mce_kind_type;

    typedef struct packed {
        mce_kind_type kind;
        logic [2:0]   req_type;
        logic [3:0]   channel;
        logic [4:0]   device_id;
        logic [15:0]  bit_mask;
        logic [4:0]   rank;
        logic [4:0]   wdb_id;
    } mce_event_type;

    typedef struct packed {
        logic        valid_second;
        logic        valid_first;
        logic [5:0]  reserved_hi;
        logic [4:0]  second_rank;
        logic [4:0]  first_rank;
        logic [15:0] second_mask;
        logic [15:0] first_mask;
        logic [4:0]  info_13_9;
        logic [8:0]  addr_info;
    } mce_misc_type;

    typedef struct packed {
        logic [26:0] upper;
        logic        reserved_37;
        logic [4:0]  first_device;
        logic [15:0] model_code;
        logic [15:0] arch_error_code;
    } mce_status_type;

endpackage
